/* File: src/crtcu_pkg.sv */
// Purpose: shared constants of the crt command and status unit
// Assumes: 8-bit host bus, one character clock
// Notes:   command code sits in data bits 7:5
package crtcu_pkg;
   // -----------------------------------------------------------
   // command codes (upper three bits of a command byte)
   // -----------------------------------------------------------
   localparam logic [2:0] CMD_RESET     = 3'h0;
   localparam logic [2:0] CMD_START     = 3'h1;
   localparam logic [2:0] CMD_STOP      = 3'h2;
   localparam logic [2:0] CMD_READ_PEN  = 3'h3;
   localparam logic [2:0] CMD_LOAD_CURS = 3'h4;
   localparam logic [2:0] CMD_IRQ_ON    = 3'h5;
   localparam logic [2:0] CMD_IRQ_OFF   = 3'h6;
   localparam logic [2:0] CMD_PRESET    = 3'h7;

   // -----------------------------------------------------------
   // parameter byte counts
   // -----------------------------------------------------------
   localparam logic [2:0] RESET_PARAMS  = 3'h4;
   localparam logic [2:0] PEN_PARAMS    = 3'h2;
   localparam logic [2:0] CURS_PARAMS   = 3'h2;

   // -----------------------------------------------------------
   // status word bit positions (bit 7 reads zero)
   // -----------------------------------------------------------
   localparam int ST_IRQ_ENABLE  = 6;
   localparam int ST_IRQ_PENDING = 5;
   localparam int ST_PEN_HIT     = 4;
   localparam int ST_BAD_CMD     = 3;
   localparam int ST_VIDEO_ON    = 2;
   localparam int ST_UNDERRUN    = 1;
   localparam int ST_FIFO_OVR    = 0;

   // -----------------------------------------------------------
   // timing and reset values
   // -----------------------------------------------------------
   localparam logic [1:0] PRESET_CYCLES = 2'h2;
   localparam logic [7:0] BYTE_RESET    = 8'h00;
   localparam logic [3:0] BUS_IDLE      = 4'hF;   // csN, rdN, wrN high, select high

   typedef enum logic [1:0] {
      PH_IDLE  = 2'b00,
      PH_WRPAR = 2'b01,
      PH_RDPAR = 2'b10
   } crtcu_phase_t;

   typedef struct packed {
      crtcu_phase_t phase;
      logic [2:0]   curCmd;
      logic [2:0]   paramLeft;
      logic [2:0]   paramIdx;
      logic [6:0]   flags;
      logic [7:0]   cursorChar;
      logic [7:0]   cursorRow;
      logic [7:0]   penChar;
      logic [7:0]   penRow;
      logic [7:0]   readData;
      logic         wrSel;
      logic         wrA0;
      logic [7:0]   wrData;
      logic         wrPrev;
      logic         rdSel;
      logic         rdA0;
      logic         rdPrev;
      logic         penPrev;
      logic [1:0]   presetCnt;
      logic         counterHold;
      logic         dmaOn;
      logic         duBlank;
   } crtcu_state_t;
endpackage : crtcu_pkg

/* File: src/crtcu_sync.sv */
// Purpose: two-flop synchroniser for pin inputs
// Assumes: inputs are quasi-static levels
// Notes:   first stage feeds only the second stage
`timescale 1ns/10ps
module crtcu_sync #(
   parameter int              WIDTH   = 1,
   parameter logic [WIDTH-1:0] RST_VAL = '0
) (
   input  wire logic             clk,
   input  wire logic             rst,
   input  wire logic [WIDTH-1:0] din,
   output      logic [WIDTH-1:0] dout
);
   logic [WIDTH-1:0] stage1_ff;

   // a zero-width synchroniser has nothing to carry
   if (WIDTH < 1) begin : g_width_check
      $error("crtcu_sync needs a width of at least one");
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         stage1_ff <= RST_VAL;
         dout      <= RST_VAL;
      end else begin
         stage1_ff <= din;
         dout      <= stage1_ff;
      end
   end
endmodule : crtcu_sync

/* File: src/crt_command_status_unit.sv */
// Purpose: command decoder and status word of a crt display controller
// Assumes: host pins are asynchronous; frame events come from logic on clk
// Notes:   writes taken at the synchronised rising edge of the write strobe
//
// Functional notes
// R1: read-pen command returns pen character then pen row on parameter reads
// R2: read-pen command leaves all status flags unchanged
// R3: load-cursor stores next two parameter writes as cursor character and row
// R4: enable-interrupt command sets interrupt-enable flag
// R5: disable-interrupt command clears interrupt-enable flag
// R6: preset command loads timing counters to top-left over two clocks
// R7: counters stay frozen after preset until another command arrives
// R8: interrupt-enable gates the retrace interrupt and follows the commands
// R9: start display sets interrupt-enable, reset command clears it
// R10: pending interrupt set at last-row start when enabled, cleared by status read
// R11: pen flag set when pen rises and position captured, cleared by status read
// R12: wrong parameter count sets bad-command flag, cleared by status read
// R13: video flag set by start, cleared by stop or reset
// R14: underrun sets flag, halts dma, blanks until retrace ends; read clears
// R15: attribute fifo overrun sets flag, cleared by status read
// R16: status byte is 0, ie, ir, lp, ic, ve, du, fo from bit 7 down
// R17: read-cleared flags clear only after the status read completes
// R18: select high writes command and reads status, low accesses parameters
// R19: host sends exactly the parameter bytes each command needs
// R20: start display enables interrupts, dma and video
// R21: reset command stops dma, disables interrupts and blanks the screen
`timescale 1ns/10ps
module crt_command_status_unit
   import crtcu_pkg::*;
(
   input  wire logic       clk,
   input  wire logic       rst,
   input  wire logic       csN,
   input  wire logic       rdN,
   input  wire logic       wrN,
   input  wire logic       registerSelectLine,
   input  wire logic [7:0] dataIn,
   output      logic [7:0] dataOut,
   output      logic       dataOe,
   input  wire logic       penSenseInput,
   input  wire logic [7:0] charPosIn,
   input  wire logic [7:0] rowPosIn,
   input  wire logic       lastRowStart,
   input  wire logic       retraceEnd,
   input  wire logic       dmaUnderrun,
   input  wire logic       fifoOverrun,
   output      logic       irqOut,
   output      logic       dmaEnable,
   output      logic       videoBlank,
   output      logic [7:0] cursorChar,
   output      logic [7:0] cursorRow,
   output      logic       presetLoad,
   output      logic       counterHold
);
   // -----------------------------------------------------------
   // pin synchronisers
   // -----------------------------------------------------------
   logic [3:0]   busSync;
   logic [7:0]   dataSync;
   logic         penSync;
   crtcu_state_t cur_ff;
   crtcu_state_t nxt_cur;
   logic         csActN;
   logic         rdSyncN;
   logic         wrSyncN;
   logic         selSync;
   logic         wrTaken;
   logic         rdStart;
   logic         rdDone;
   logic [7:0]   statusByte;

   crtcu_sync #(.WIDTH(4), .RST_VAL(BUS_IDLE)) u_busSync (
      .clk  (clk),
      .rst  (rst),
      .din  ({csN, rdN, wrN, registerSelectLine}),
      .dout (busSync)
   );
   crtcu_sync #(.WIDTH(8), .RST_VAL(BYTE_RESET)) u_dataSync (
      .clk  (clk),
      .rst  (rst),
      .din  (dataIn),
      .dout (dataSync)
   );
   crtcu_sync #(.WIDTH(1), .RST_VAL(1'b0)) u_penSync (
      .clk  (clk),
      .rst  (rst),
      .din  (penSenseInput),
      .dout (penSync)
   );

   assign csActN  = busSync[3];
   assign rdSyncN = busSync[2];
   assign wrSyncN = busSync[1];
   assign selSync = busSync[0];
   assign wrTaken = wrSyncN && !cur_ff.wrPrev && cur_ff.wrSel;
   assign rdStart = !rdSyncN && cur_ff.rdPrev && !csActN;
   assign rdDone  = rdSyncN && !cur_ff.rdPrev && cur_ff.rdSel;

   // -----------------------------------------------------------
   // status word and outputs
   // -----------------------------------------------------------
   assign statusByte  = {1'b0, cur_ff.flags};                               // R16
   assign dataOut     = cur_ff.readData;
   assign dataOe      = cur_ff.rdSel && !rdSyncN;
   assign irqOut      = cur_ff.flags[ST_IRQ_PENDING];
   assign dmaEnable   = cur_ff.dmaOn && !cur_ff.duBlank;                    // R14
   assign videoBlank  = !cur_ff.flags[ST_VIDEO_ON] || cur_ff.duBlank;       // R21
   assign cursorChar  = cur_ff.cursorChar;
   assign cursorRow   = cur_ff.cursorRow;
   assign presetLoad  = (cur_ff.presetCnt != 2'h0);                         // R6
   assign counterHold = cur_ff.counterHold;                                 // R7

   // -----------------------------------------------------------
   // next state
   // -----------------------------------------------------------
   always_comb begin
      nxt_cur         = cur_ff;
      nxt_cur.wrPrev  = wrSyncN;
      nxt_cur.rdPrev  = rdSyncN;
      nxt_cur.penPrev = penSync;
      // address, select and data are sampled while the strobe is low and held once it rises
      if (!wrSyncN) begin
         nxt_cur.wrSel  = !csActN;
         nxt_cur.wrA0   = selSync;
         nxt_cur.wrData = dataSync;
      end
      if (cur_ff.presetCnt != 2'h0) begin
         nxt_cur.presetCnt = cur_ff.presetCnt - 2'h1;                       // R6
      end

      // clears come first so that a same-cycle event wins
      if (rdDone && cur_ff.rdA0) begin                                      // R17
         nxt_cur.rdSel                  = 1'b0;
         nxt_cur.flags[ST_IRQ_PENDING]  = 1'b0;                             // R10
         nxt_cur.flags[ST_PEN_HIT]      = 1'b0;                             // R11
         nxt_cur.flags[ST_BAD_CMD]      = 1'b0;                             // R12
         nxt_cur.flags[ST_UNDERRUN]     = 1'b0;                             // R14
         nxt_cur.flags[ST_FIFO_OVR]     = 1'b0;                             // R15
      end else if (rdDone) begin
         nxt_cur.rdSel = 1'b0;
      end

      if (rdStart) begin
         nxt_cur.rdSel = 1'b1;
         nxt_cur.rdA0  = selSync;
         if (selSync) begin
            nxt_cur.readData = statusByte;                                  // R18
         end else if (cur_ff.phase == PH_RDPAR) begin
            nxt_cur.readData  = (cur_ff.paramIdx == 3'h0) ? cur_ff.penChar
                                                          : cur_ff.penRow;  // R1
            nxt_cur.paramIdx  = cur_ff.paramIdx + 3'h1;
            nxt_cur.paramLeft = cur_ff.paramLeft - 3'h1;
            if (cur_ff.paramLeft == 3'h1) begin
               nxt_cur.phase = PH_IDLE;
            end
         end else begin
            nxt_cur.readData          = BYTE_RESET;
            nxt_cur.flags[ST_BAD_CMD] = 1'b1;                               // R12
         end
      end

      if (wrTaken && cur_ff.wrA0) begin                                     // R18
         if (cur_ff.paramLeft != 3'h0) begin
            nxt_cur.flags[ST_BAD_CMD] = 1'b1;                               // R12
         end
         nxt_cur.curCmd      = cur_ff.wrData[7:5];
         nxt_cur.paramIdx    = 3'h0;
         nxt_cur.paramLeft   = 3'h0;
         nxt_cur.phase       = PH_IDLE;
         nxt_cur.counterHold = 1'b0;                                        // R7
         case (cur_ff.wrData[7:5])
            CMD_RESET: begin
               nxt_cur.phase                 = PH_WRPAR;
               nxt_cur.paramLeft             = RESET_PARAMS;
               nxt_cur.dmaOn                 = 1'b0;                        // R21
               nxt_cur.flags[ST_IRQ_ENABLE]  = 1'b0;                        // R9
               nxt_cur.flags[ST_VIDEO_ON]    = 1'b0;                        // R13
            end
            CMD_START: begin
               nxt_cur.dmaOn                 = 1'b1;                        // R20
               nxt_cur.flags[ST_IRQ_ENABLE]  = 1'b1;                        // R9
               nxt_cur.flags[ST_VIDEO_ON]    = 1'b1;                        // R13
            end
            CMD_STOP: begin
               nxt_cur.flags[ST_VIDEO_ON]    = 1'b0;                        // R13
            end
            CMD_READ_PEN: begin
               nxt_cur.phase     = PH_RDPAR;                                // R2
               nxt_cur.paramLeft = PEN_PARAMS;
            end
            CMD_LOAD_CURS: begin
               nxt_cur.phase     = PH_WRPAR;
               nxt_cur.paramLeft = CURS_PARAMS;
            end
            CMD_IRQ_ON: begin
               nxt_cur.flags[ST_IRQ_ENABLE]  = 1'b1;                        // R4
            end
            CMD_IRQ_OFF: begin
               nxt_cur.flags[ST_IRQ_ENABLE]  = 1'b0;                        // R5
            end
            CMD_PRESET: begin
               nxt_cur.presetCnt   = PRESET_CYCLES;                         // R6
               nxt_cur.counterHold = 1'b1;                                  // R7
            end
            default: begin
               nxt_cur.phase = PH_IDLE;
            end
         endcase
      end else if (wrTaken) begin
         if (cur_ff.phase == PH_WRPAR) begin
            if (cur_ff.curCmd == CMD_LOAD_CURS) begin
               if (cur_ff.paramIdx == 3'h0) begin
                  nxt_cur.cursorChar = cur_ff.wrData;                       // R3
               end else begin
                  nxt_cur.cursorRow = cur_ff.wrData;                        // R3
               end
            end
            nxt_cur.paramIdx  = cur_ff.paramIdx + 3'h1;
            nxt_cur.paramLeft = cur_ff.paramLeft - 3'h1;
            if (cur_ff.paramLeft == 3'h1) begin
               nxt_cur.phase = PH_IDLE;
            end
         end else begin
            nxt_cur.flags[ST_BAD_CMD] = 1'b1;                               // R12
         end
      end

      // frame and datapath events set their flags last
      if (lastRowStart && cur_ff.flags[ST_IRQ_ENABLE]) begin
         nxt_cur.flags[ST_IRQ_PENDING] = 1'b1;                              // R8
      end
      if (penSync && !cur_ff.penPrev) begin
         nxt_cur.penChar           = charPosIn;
         nxt_cur.penRow            = rowPosIn;
         nxt_cur.flags[ST_PEN_HIT] = 1'b1;                                  // R11
      end
      if (retraceEnd) begin
         nxt_cur.duBlank = 1'b0;
      end
      if (dmaUnderrun) begin
         nxt_cur.flags[ST_UNDERRUN] = 1'b1;                                 // R14
         nxt_cur.duBlank            = 1'b1;
      end
      if (fifoOverrun) begin
         nxt_cur.flags[ST_FIFO_OVR] = 1'b1;                                 // R15
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         cur_ff        <= '0;
         cur_ff.wrPrev <= 1'b1;
         cur_ff.rdPrev <= 1'b1;
      end else begin
         cur_ff <= nxt_cur;
      end
   end

   // -----------------------------------------------------------
   // checks
   // -----------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   a_pen_first_byte: assert property (                                      // R1
      rdStart && !selSync && cur_ff.phase == PH_RDPAR && cur_ff.paramIdx == 3'h0
      |=> dataOut == $past(cur_ff.penChar))
      else $error("pen character not returned");
   a_pen_keeps_flags: assert property (                                     // R2
      wrTaken && cur_ff.wrA0 && cur_ff.wrData[7:5] == CMD_READ_PEN
      && cur_ff.paramLeft == 3'h0 && !rdDone && !lastRowStart && !dmaUnderrun
      && !fifoOverrun && !(penSync && !cur_ff.penPrev)
      |=> cur_ff.flags == $past(cur_ff.flags))
      else $error("read pen changed flags");
   a_cursor_char: assert property (                                         // R3
      wrTaken && !cur_ff.wrA0 && cur_ff.phase == PH_WRPAR
      && cur_ff.curCmd == CMD_LOAD_CURS && cur_ff.paramIdx == 3'h0
      |=> cursorChar == $past(cur_ff.wrData))
      else $error("cursor character not stored");
   a_irq_on_cmd: assert property (                                          // R4
      wrTaken && cur_ff.wrA0 && cur_ff.wrData[7:5] == CMD_IRQ_ON
      |=> statusByte[ST_IRQ_ENABLE])
      else $error("enable interrupt ignored");
   a_irq_off_cmd: assert property (                                         // R5
      wrTaken && cur_ff.wrA0 && cur_ff.wrData[7:5] == CMD_IRQ_OFF
      |=> !statusByte[ST_IRQ_ENABLE])
      else $error("disable interrupt ignored");
   a_preset_pulse: assert property (                                        // R6
      wrTaken && cur_ff.wrA0 && cur_ff.wrData[7:5] == CMD_PRESET
      |=> presetLoad [*2] ##1 !presetLoad)
      else $error("preset not two cycles");
   a_hold_until_cmd: assert property (                                      // R7
      counterHold && !(wrTaken && cur_ff.wrA0) |=> counterHold)
      else $error("counter hold dropped early");
   a_irq_gated: assert property (                                           // R10
      $rose(irqOut) |-> $past(lastRowStart) && $past(cur_ff.flags[ST_IRQ_ENABLE]))
      else $error("interrupt without enable");
   a_status_clear: assert property (                                        // R17
      rdDone && cur_ff.rdA0 && !dmaUnderrun |=> !statusByte[ST_UNDERRUN])
      else $error("underrun not cleared by read");
   a_underrun_blank: assert property (                                      // R14
      dmaUnderrun || (cur_ff.duBlank && !retraceEnd) |=> videoBlank && !dmaEnable)
      else $error("underrun did not blank");
endmodule : crt_command_status_unit

/* File: testbench/crtcu_host_model.sv */
// Purpose: host processor model driving the command/parameter bus pins
// Assumes: pins change just after a rising clk edge, by non-blocking assignment
// Notes:   strobes stay low 5 clocks and high at least 5, above the 3-clock minimum
`timescale 1ns/10ps
module crtcu_host_model (
   input  wire logic       clk,
   output      logic       csN,
   output      logic       rdN,
   output      logic       wrN,
   output      logic       registerSelectLine,
   output      logic [7:0] dataIn
);
   initial begin
      csN                = 1'b1;
      rdN                = 1'b1;
      wrN                = 1'b1;
      registerSelectLine = 1'b1;
      dataIn             = 8'h00;
   end

   // -----------------------------------------------------------
   // bus cycles
   // -----------------------------------------------------------
   task automatic busWrite(input logic sel, input logic [7:0] data);
      @(posedge clk);
      csN                <= 1'b0;
      wrN                <= 1'b0;
      registerSelectLine <= sel;
      dataIn             <= data;
      repeat (5) @(posedge clk);
      wrN <= 1'b1;
      @(posedge clk);
      csN    <= 1'b1;
      dataIn <= ~data;   // released bus must not look like the last byte
      repeat (5) @(posedge clk);
   endtask : busWrite

   task automatic busRead(input logic sel);
      @(posedge clk);
      csN                <= 1'b0;
      rdN                <= 1'b0;
      registerSelectLine <= sel;
      repeat (5) @(posedge clk);
      rdN <= 1'b1;
      @(posedge clk);
      csN <= 1'b1;
      repeat (5) @(posedge clk);
   endtask : busRead
endmodule : crtcu_host_model

/* File: testbench/crt_command_status_unit_test.sv */
// Purpose: self-checking bench of the crt command and status unit
// Assumes: host model drives the bus; bench drives frame events and pen
// Notes:   read bytes are queued by the driver and checked when dataOe rises
`timescale 1ns/10ps
module crt_command_status_unit_test;
   import crtcu_pkg::*;
   logic       clk = 1'b0;
   logic       rst;
   logic       csN, rdN, wrN, registerSelectLine;
   logic [7:0] dataIn, dataOut, charPosIn, rowPosIn, cursorChar, cursorRow, a, b;
   logic       dataOe, penSenseInput, irqOut, dmaEnable, videoBlank;
   logic       presetLoad, counterHold;
   logic       oePrev = 1'b0;
   logic [3:0] evt;
   logic [7:0] expQ[$];
   int         err_total = 0;
   int         comparisons = 0;
   int         presetSeen = 0;
   int         seed = 98;
   int         n0;

   always #4 clk = ~clk;

   crtcu_host_model crtcu_host_model_i (
      .clk(clk), .csN(csN), .rdN(rdN), .wrN(wrN),
      .registerSelectLine(registerSelectLine), .dataIn(dataIn));

   crt_command_status_unit crt_command_status_unit_i (
      .clk(clk), .rst(rst), .csN(csN), .rdN(rdN), .wrN(wrN),
      .registerSelectLine(registerSelectLine), .dataIn(dataIn),
      .dataOut(dataOut), .dataOe(dataOe), .penSenseInput(penSenseInput),
      .charPosIn(charPosIn), .rowPosIn(rowPosIn), .lastRowStart(evt[0]),
      .retraceEnd(evt[1]), .dmaUnderrun(evt[2]), .fifoOverrun(evt[3]),
      .irqOut(irqOut), .dmaEnable(dmaEnable), .videoBlank(videoBlank),
      .cursorChar(cursorChar), .cursorRow(cursorRow),
      .presetLoad(presetLoad), .counterHold(counterHold));

   // -----------------------------------------------------------
   // compare tasks and verdict
   // -----------------------------------------------------------
   task automatic checkByte(input logic [7:0] got, input logic [7:0] exp);
      comparisons++;
      if (got !== exp) begin
         err_total++;
         $display("MISMATCH t=%0t byte got %h expected %h", $time, got, exp);
      end
   endtask : checkByte

   task automatic checkBit(input logic got, input logic exp, input string what);
      @(negedge clk);
      comparisons++;
      if (got !== exp) begin
         err_total++;
         $display("MISMATCH t=%0t %s got %b expected %b", $time, what, got, exp);
      end
   endtask : checkBit

   task automatic summarize();
      $display("comparisons %0d mismatches %0d", comparisons, err_total);
      if (err_total == 0 && comparisons > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : summarize

   // -----------------------------------------------------------
   // driver helpers
   // -----------------------------------------------------------
   task automatic cmd(input logic [7:0] d);
      crtcu_host_model_i.busWrite(1'b1, d);
   endtask : cmd

   task automatic par(input logic [7:0] d);
      crtcu_host_model_i.busWrite(1'b0, d);
   endtask : par

   task automatic rd(input logic sel, input logic [7:0] exp);
      expQ.push_back(exp);
      crtcu_host_model_i.busRead(sel);
   endtask : rd

   task automatic pulse(input int i);
      @(posedge clk);
      evt[i] <= 1'b1;
      @(posedge clk);
      evt <= 4'h0;
      @(posedge clk);
   endtask : pulse

   // one expected byte leaves the queue per read answer
   always @(negedge clk) begin
      if (dataOe === 1'b1 && oePrev !== 1'b1) begin
         if (expQ.size() == 0) begin
            err_total++;
            $display("MISMATCH t=%0t unexpected read answer", $time);
         end else begin
            checkByte(dataOut, expQ.pop_front());
         end
      end
      oePrev <= dataOe;
   end

   always @(posedge clk) begin
      if (presetLoad === 1'b1) begin
         presetSeen <= presetSeen + 1;
      end
   end

   initial begin
      #100000;
      err_total++;
      $display("MISMATCH t=%0t run did not finish in time", $time);
      summarize();
   end

   // -----------------------------------------------------------
   // main sequence
   // -----------------------------------------------------------
   initial begin
      rst = 1'b1;
      evt = 4'h0;
      penSenseInput = 1'b0;
      charPosIn = 8'h00;
      rowPosIn = 8'h00;
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      rd(1'b1, 8'h00);
      checkBit(videoBlank, 1'b1, "blank after reset");
      cmd(8'h20);
      rd(1'b1, 8'h44);
      checkBit(dmaEnable, 1'b1, "dma on");
      checkBit(videoBlank, 1'b0, "video on");
      cmd(8'hC0);
      rd(1'b1, 8'h04);
      pulse(0);
      checkBit(irqOut, 1'b0, "irq while disabled");
      cmd(8'hA0);
      rd(1'b1, 8'h44);
      pulse(0);
      checkBit(irqOut, 1'b1, "irq raised");
      rd(1'b1, 8'h64);
      rd(1'b1, 8'h44);
      checkBit(irqOut, 1'b0, "irq cleared");
      a = 8'($random(seed));
      b = 8'($random(seed));
      cmd(8'h80);
      par(a);
      par(b);
      @(negedge clk);
      checkByte(cursorChar, a);
      checkByte(cursorRow, b);
      rd(1'b1, 8'h44);
      a = 8'($random(seed));
      b = 8'($random(seed));
      @(posedge clk);
      charPosIn     <= a;
      rowPosIn      <= b;
      penSenseInput <= 1'b1;
      repeat (6) @(posedge clk);
      charPosIn     <= ~a;
      rowPosIn      <= ~b;
      penSenseInput <= 1'b0;
      cmd(8'h60);
      rd(1'b0, a);
      rd(1'b0, b);
      rd(1'b1, 8'h54);
      rd(1'b1, 8'h44);
      cmd(8'h80);
      par(a);
      cmd(8'hA0);
      rd(1'b1, 8'h4C);
      rd(1'b0, 8'h00);
      rd(1'b1, 8'h4C);
      rd(1'b1, 8'h44);
      pulse(2);
      checkBit(dmaEnable, 1'b0, "dma halted");
      checkBit(videoBlank, 1'b1, "underrun blank");
      pulse(1);
      checkBit(videoBlank, 1'b0, "blank ends");
      rd(1'b1, 8'h46);
      rd(1'b1, 8'h44);
      pulse(3);
      rd(1'b1, 8'h45);
      rd(1'b1, 8'h44);
      n0 = presetSeen;
      cmd(8'hE0);
      repeat (10) @(posedge clk);
      checkBit(counterHold, 1'b1, "counters frozen");
      checkByte(8'(presetSeen - n0), 8'h02);
      cmd(8'hA0);
      checkBit(counterHold, 1'b0, "counters run");
      cmd(8'h40);
      rd(1'b1, 8'h40);
      checkBit(videoBlank, 1'b1, "stop blanks");
      cmd(8'h00);
      repeat (4) par(8'($random(seed)));
      rd(1'b1, 8'h00);
      checkBit(dmaEnable, 1'b0, "reset stops dma");
      repeat (4) @(posedge clk);
      if (expQ.size() != 0) begin
         err_total++;
         $display("MISMATCH t=%0t reads left unanswered", $time);
      end
      summarize();
   end
endmodule : crt_command_status_unit_test
